// [rtl/mcr_pkg.sv]
// Shared constants for the macrocell register block.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
package mcr_pkg;
   localparam int NUM_MC      = 16;
   localparam int CHAIN_LEN   = 8;
   localparam int PT_PER_MC   = 5;
   localparam int MAX_SETS    = 3;
   localparam int CFG_W       = 10;
   // Register byte offsets
   localparam logic [7:0] OFS_CFG_BASE = 8'h00;
   localparam logic [7:0] OFS_CLKNET   = 8'h40;
   localparam logic [7:0] OFS_STATE    = 8'h44;
   localparam logic [7:0] OFS_EXPSET   = 8'h48;
   // Per-macrocell config fields
   localparam int F_TYPE_LO   = 0;
   localparam int F_BYPASS    = 2;
   localparam int F_CMODE_LO  = 3;
   localparam int F_CLKNET    = 5;
   localparam int F_GCLR_EN   = 6;
   localparam int F_FAST      = 7;
   localparam int F_BORROW_LO = 8;
   // Clock network config fields
   localparam int F_NET0_SEL  = 0;
   localparam int F_NET0_INV  = 1;
   localparam int F_NET1_SEL  = 2;
   localparam int F_NET1_INV  = 3;
   // Reset values
   localparam logic [CFG_W-1:0] CFG_RST    = 10'h000;
   localparam logic [3:0]       CLKNET_RST = 4'h4;
   // Flipflop types and clock modes
   localparam logic [1:0] FF_D  = 2'h0;
   localparam logic [1:0] FF_T  = 2'h1;
   localparam logic [1:0] FF_JK = 2'h2;
   localparam logic [1:0] FF_SR = 2'h3;
   localparam logic [1:0] CM_GLOBAL = 2'h0;
   localparam logic [1:0] CM_GATED  = 2'h1;
   localparam logic [1:0] CM_ARRAY  = 2'h2;
   // Fast input path timing
   localparam int CLK_PERIOD_PS  = 10000;
   localparam int FAST_SETUP_PS  = 2500;
   localparam int FAST_SETUP_CYC = (FAST_SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage

// [rtl/mcr_pin_sync.sv]
// Three-stage pin synchroniser with agreement filter.
// Assumes inputs asynchronous to sys_clk_i.
`timescale 1ns/1ps
module mcr_pin_sync #(
   parameter int             W       = 1,
   parameter logic [W-1:0]   RST_VAL = '0
) (
   input  wire logic         sys_clk_i,   // System clock
   input  wire logic         arst_n_i,    // Async reset, active low
   input  wire logic [W-1:0] pin_i,       // Raw pin levels
   output logic      [W-1:0] level_o      // Filtered levels
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s1 <= RST_VAL;
         s2 <= RST_VAL;
         s3 <= RST_VAL;
      end else begin
         s1 <= pin_i;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // Change accepted once second and third stages agree
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         level_o <= RST_VAL;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2[i] == s3[i]) begin
               level_o[i] <= s3[i];
            end
         end
      end
   end
endmodule

// [rtl/mcr_expander_chain.sv]
// Parallel expander sharing across one chain of eight macrocells.
// Assumes product terms come from same-clock array logic.
`timescale 1ns/1ps
module mcr_expander_chain
   import mcr_pkg::*;
(
   input  wire logic [CHAIN_LEN*PT_PER_MC-1:0] pterm_i,    // Five terms per macrocell
   input  wire logic [2*CHAIN_LEN-1:0]         borrow_i,   // Requested sets per macrocell
   output logic      [CHAIN_LEN-1:0]           sum_o,      // OR-gate outputs
   output logic      [2*CHAIN_LEN-1:0]         sets_o      // Sets actually borrowed
);
   int   owner [CHAIN_LEN];
   logic [1:0] eff;
   logic [2:0] cnt;

   always_comb begin
      sum_o  = '0;
      sets_o = '0;
      eff    = '0;
      cnt    = '0;
      // Nearest higher borrower claims a lender; top never lends
      for (int i = 0; i < CHAIN_LEN; i++) begin
         owner[i] = -1;
         for (int j = CHAIN_LEN - 1; j > i; j--) begin
            eff = (int'(borrow_i[2*j +: 2]) > j) ? 2'(j) : borrow_i[2*j +: 2];
            if (int'(eff) >= j - i) begin
               owner[i] = j;
            end
         end
      end
      for (int j = 0; j < CHAIN_LEN; j++) begin
         cnt = '0;
         if (owner[j] < 0) begin
            sum_o[j] = |pterm_i[PT_PER_MC*j +: PT_PER_MC];
         end
         for (int i = 0; i < j; i++) begin
            if (owner[i] == j) begin
               sum_o[j] = sum_o[j] | (|pterm_i[PT_PER_MC*i +: PT_PER_MC]);
               cnt      = cnt + 3'h1;
            end
         end
         sets_o[2*j +: 2] = (cnt > 3'(MAX_SETS)) ? 2'(MAX_SETS) : cnt[1:0];
      end
   end
endmodule

// [rtl/mcr_macrocell_block.sv]
// Sixteen configurable macrocells of one logic_block_group.
// Assumes array terms on sys_clk_i and pins asynchronous to it.
//
// The implementer's own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps

// Behaviour
// - Each storage element acts as a D, T, JK or SR flipflop by its own config.
// - A bypass option sends the sum-of-products straight to the macrocell output.
// - Each register picks global, gated global or array clocking.
// - In gated mode the register captures on the global clock only while its enable is high.
// - In array mode a product-term edge clocks the register.
// - Two global networks each take true or inverted level of either clock pin.
// - Product-term preset and clear act asynchronously while their terms are high.
// - Each register clear may also follow the active-low global clear pin.
// - Registers power up to the chosen value, or low in variants without the option.
// - Each pin has a fast path to its register data input bypassing the array.
// - The OR gate takes its own five terms plus up to fifteen borrowed ones.
// - Borrowing uses up to three sets of five, each adding one delay increment.
// - Macrocells 1 to 8 and 9 to 16 form two separate sharing chains.
// - A macrocell borrows only from lower-numbered neighbours within its set count that no nearer borrower has claimed.
// - The lowest of a chain only lends and the highest only borrows.
module mcr_macrocell_block
   import mcr_pkg::*;
#(
   parameter bit                SELECTABLE_INIT = 1'b1,
   parameter logic [NUM_MC-1:0] POWERUP_VALUE   = 16'h0000
) (
   input  wire logic                        sys_clk_i,             // System clock
   input  wire logic                        arst_n_i,              // Async reset, active low
   input  wire logic [7:0]                  avs_address_i,         // Byte address
   input  wire logic                        avs_read_i,            // Read request
   input  wire logic                        avs_write_i,           // Write request
   input  wire logic [31:0]                 avs_writedata_i,       // Write data
   input  wire logic [3:0]                  avs_byteenable_i,      // Byte lanes
   output logic      [31:0]                 avs_readdata_o,        // Read data
   output logic                             avs_waitrequest_o,     // Stall
   input  wire logic                        global_clock_pin_a_i,  // Clock pin A
   input  wire logic                        global_clock_pin_b_i,  // Clock pin B
   input  wire logic                        global_clear_pin_n_i,  // Global clear, low active
   input  wire logic [NUM_MC-1:0]           fast_pin_i,            // Fast input pins
   input  wire logic [NUM_MC*PT_PER_MC-1:0] pterm_i,               // Data product terms
   input  wire logic [NUM_MC-1:0]           aux_term_i,            // K or R term
   input  wire logic [NUM_MC-1:0]           clk_term_i,            // Array clock term
   input  wire logic [NUM_MC-1:0]           ena_term_i,            // Clock enable term
   input  wire logic [NUM_MC-1:0]           preset_term_i,         // Preset term
   input  wire logic [NUM_MC-1:0]           clear_term_i,          // Clear term
   output logic      [NUM_MC-1:0]           mc_out_o               // Macrocell outputs
);
   logic [CFG_W-1:0]      cfg [NUM_MC];
   logic [3:0]            clknet_cfg;
   logic                  acc_done;
   logic                  req;
   logic [1:0]            pins_f;
   logic                  gclr_n_f;
   logic [NUM_MC-1:0]     fast_f;
   logic [1:0]            net_lvl;
   logic [1:0]            net_prev;
   logic [1:0]            gtick;
   logic [NUM_MC-1:0]     clk_term_prev;
   logic [NUM_MC-1:0]     atick;
   logic [NUM_MC-1:0]     tick;
   logic [NUM_MC-1:0]     sum;
   logic [2*NUM_MC-1:0]   borrow;
   logic [2*NUM_MC-1:0]   expander_set_delay;
   logic [NUM_MC-1:0]     state;
   logic [NUM_MC-1:0]     clr_act;
   logic [NUM_MC-1:0]     pre_act;
   logic [NUM_MC-1:0]     d_src;
   logic [31:0]           rd_mux;

   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic is_cfg(input logic [7:0] a);
      return a[7:6] == OFS_CFG_BASE[7:6];
   endfunction

   function automatic logic ff_next(input logic [1:0] ty,
                                    input logic       d,
                                    input logic       aux,
                                    input logic       q);
      logic r;
      r = q;
      case (ty)
         FF_D:    r = d;
         FF_T:    r = d ? ~q : q;
         FF_JK:   r = (d & aux) ? ~q : (d ? 1'b1 : (aux ? 1'b0 : q));
         FF_SR:   r = d ? 1'b1 : (aux ? 1'b0 : q);
         default: r = q;
      endcase
      return r;
   endfunction

   // Register bus: one wait cycle, answer on the second edge
   assign req               = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = req & ~acc_done;

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         acc_done <= 1'b0;
      end else begin
         acc_done <= req & ~acc_done;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (is_cfg(avs_address_i)) begin
         rd_mux[CFG_W-1:0] = cfg[avs_address_i[5:2]];
      end else if (avs_address_i[7:2] == OFS_CLKNET[7:2]) begin
         rd_mux[3:0] = clknet_cfg;
      end else if (avs_address_i[7:2] == OFS_STATE[7:2]) begin
         rd_mux[NUM_MC-1:0] = state;
      end else if (avs_address_i[7:2] == OFS_EXPSET[7:2]) begin
         rd_mux = expander_set_delay;
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (avs_read_i & ~acc_done) begin
         avs_readdata_o <= rd_mux;
      end
   end

   // Configuration writes, taken at the edge where waitrequest is low
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int m = 0; m < NUM_MC; m++) begin
            cfg[m] <= CFG_RST;
         end
      end else if (avs_write_i & acc_done & is_cfg(avs_address_i)) begin
         cfg[avs_address_i[5:2]] <= CFG_W'(be_merge(32'(cfg[avs_address_i[5:2]]),
                                                    avs_writedata_i, avs_byteenable_i));
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         clknet_cfg <= CLKNET_RST;
      end else if (avs_write_i & acc_done & (avs_address_i[7:2] == OFS_CLKNET[7:2])) begin
         clknet_cfg <= 4'(be_merge(32'(clknet_cfg), avs_writedata_i, avs_byteenable_i));
      end
   end

   // Pin synchronisers
   mcr_pin_sync #(.W(2), .RST_VAL(2'h0)) u_clk_sync (
      .sys_clk_i (sys_clk_i),
      .arst_n_i  (arst_n_i),
      .pin_i     ({global_clock_pin_b_i, global_clock_pin_a_i}),
      .level_o   (pins_f)
   );

   mcr_pin_sync #(.W(1), .RST_VAL(1'b1)) u_clr_sync (
      .sys_clk_i (sys_clk_i),
      .arst_n_i  (arst_n_i),
      .pin_i     (global_clear_pin_n_i),
      .level_o   (gclr_n_f)
   );

   mcr_pin_sync #(.W(NUM_MC), .RST_VAL(16'h0000)) u_fast_sync (
      .sys_clk_i (sys_clk_i),
      .arst_n_i  (arst_n_i),
      .pin_i     (fast_pin_i),
      .level_o   (fast_f)
   );

   // Global clock networks and their rising-edge ticks
   assign net_lvl[0] = (clknet_cfg[F_NET0_SEL] ? pins_f[1] : pins_f[0])
                       ^ clknet_cfg[F_NET0_INV];
   assign net_lvl[1] = (clknet_cfg[F_NET1_SEL] ? pins_f[1] : pins_f[0])
                       ^ clknet_cfg[F_NET1_INV];
   assign gtick      = net_lvl & ~net_prev;
   assign atick      = clk_term_i & ~clk_term_prev;

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         net_prev      <= 2'h0;
         clk_term_prev <= 16'h0000;
      end else begin
         net_prev      <= net_lvl;
         clk_term_prev <= clk_term_i;
      end
   end

   // Expander chains, never joined
   genvar g;
   generate
      for (g = 0; g < NUM_MC; g++) begin : g_borrow
         assign borrow[2*g +: 2] = cfg[g][F_BORROW_LO +: 2];
      end
      for (g = 0; g < NUM_MC / CHAIN_LEN; g++) begin : g_chain
         mcr_expander_chain u_chain (
            .pterm_i  (pterm_i[g*CHAIN_LEN*PT_PER_MC +: CHAIN_LEN*PT_PER_MC]),
            .borrow_i (borrow[g*2*CHAIN_LEN +: 2*CHAIN_LEN]),
            .sum_o    (sum[g*CHAIN_LEN +: CHAIN_LEN]),
            .sets_o   (expander_set_delay[g*2*CHAIN_LEN +: 2*CHAIN_LEN])
         );
         first_lend_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
            expander_set_delay[g*2*CHAIN_LEN +: 2] == 2'h0)
            else $error("lowest macrocell of chain borrowed");
      end
   endgenerate

   // Macrocells
   generate
      for (g = 0; g < NUM_MC; g++) begin : g_mc
         logic [1:0] ty;
         logic [1:0] cm;
         logic       gt;
         assign ty = cfg[g][F_TYPE_LO +: 2];
         assign cm = cfg[g][F_CMODE_LO +: 2];
         assign gt = gtick[cfg[g][F_CLKNET]];
         // Mode 3 is unused and behaves as the plain global clock
         assign tick[g] = (cm == CM_GATED) ? (gt & ena_term_i[g]) :
                          (cm == CM_ARRAY) ? atick[g] : gt;
         assign clr_act[g] = clear_term_i[g] | (cfg[g][F_GCLR_EN] & ~gclr_n_f);
         assign pre_act[g] = preset_term_i[g];
         assign d_src[g]   = cfg[g][F_FAST] ? fast_f[g] : sum[g];

         always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               state[g] <= SELECTABLE_INIT ? POWERUP_VALUE[g] : 1'b0;
            end else if (clr_act[g]) begin
               state[g] <= 1'b0;
            end else if (pre_act[g]) begin
               state[g] <= 1'b1;
            end else if (tick[g]) begin
               state[g] <= ff_next(ty, d_src[g], aux_term_i[g], state[g]);
            end
         end

         // Preset and clear override at once, not at the next tick
         assign mc_out_o[g] = cfg[g][F_BYPASS] ? sum[g] :
                              clr_act[g] ? 1'b0 :
                              pre_act[g] ? 1'b1 : state[g];

         clear_wins_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
            (clr_act[g] && pre_act[g] && !cfg[g][F_BYPASS]) |-> !mc_out_o[g])
            else $error("preset beat clear");
         bypass_comb_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
            cfg[g][F_BYPASS] |-> (mc_out_o[g] == sum[g]))
            else $error("bypass output differs from sum");
         gated_hold_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
            (cm == CM_GATED && !ena_term_i[g] && !clr_act[g] && !pre_act[g])
            |=> $stable(state[g]))
            else $error("gated register changed without enable");
         d_capture_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
            (ty == FF_D && tick[g] && !clr_act[g] && !pre_act[g])
            |=> (state[g] == $past(d_src[g])))
            else $error("D register missed its data");
         toggle_flip_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
            (ty == FF_T && tick[g] && d_src[g] && !clr_act[g] && !pre_act[g])
            |=> (state[g] != $past(state[g])))
            else $error("T register failed to toggle");
         preset_out_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
            (pre_act[g] && !clr_act[g] && !cfg[g][F_BYPASS]) |-> mc_out_o[g])
            else $error("preset not seen at output");
         gclr_pin_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
            (cfg[g][F_GCLR_EN] && !gclr_n_f) |=> !state[g])
            else $error("global clear ignored");
         array_clk_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
            (cm == CM_ARRAY && !atick[g] && !clr_act[g] && !pre_act[g])
            |=> $stable(state[g]))
            else $error("array register clocked without term edge");
         sets_limit_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
            expander_set_delay[2*g +: 2] <= borrow[2*g +: 2])
            else $error("more sets borrowed than requested");
      end
   endgenerate

   bus_wait_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      (req && avs_waitrequest_o) |=> !avs_waitrequest_o)
      else $error("waitrequest held more than one cycle");
endmodule

// [bench/mcr_array_model.sv]
// Model of the product-term array and global clock pins feeding the block.
// Assumes the bench calls its tasks from one process, just after an edge.
`timescale 1ns/1ps
module mcr_array_model
   import mcr_pkg::*;
(
   input  wire logic                          sys_clk_i,            // System clock
   output logic                               global_clock_pin_a_o, // Clock pin A
   output logic                               global_clock_pin_b_o, // Clock pin B
   output logic      [NUM_MC*PT_PER_MC-1:0]   pterm_o               // Data product terms
);
   initial begin
      global_clock_pin_a_o = 1'b0;
      global_clock_pin_b_o = 1'b0;
      pterm_o              = '0;
   end
   task automatic set_terms(input logic [NUM_MC*PT_PER_MC-1:0] t);
      @(posedge sys_clk_i);
      pterm_o <= t;
   endtask
   // Sum bit m rides on term m mod 5 of macrocell m
   task automatic set_sum(input logic [NUM_MC-1:0] s);
      logic [NUM_MC*PT_PER_MC-1:0] t;
      t = '0;
      for (int m = 0; m < NUM_MC; m++) begin
         t[m*PT_PER_MC + m%PT_PER_MC] = s[m];
      end
      set_terms(t);
   endtask
   // Pins stand still between changes; 8 cycles cover sync, tick and update
   task automatic set_pin(input logic b, input logic lvl);
      @(posedge sys_clk_i);
      if (b) begin
         global_clock_pin_b_o <= lvl;
      end else begin
         global_clock_pin_a_o <= lvl;
      end
      repeat (8) @(posedge sys_clk_i);
   endtask
   task automatic pulse(input logic b);
      set_pin(b, 1'b1);
      set_pin(b, 1'b0);
   endtask
endmodule

// [bench/testbench.sv]
// Self-checking bench for the sixteen-macrocell block.
// Assumes the array model drives pins and data terms, the bench the rest.
`timescale 1ns/1ps
module testbench
   import mcr_pkg::*;
;
   typedef struct packed {
      logic [9:0]  cfg;
      logic [15:0] sum;
      logic [15:0] aux;
      logic [15:0] ena;
      logic [15:0] exp;
   } mcr_row_s;
   localparam mcr_row_s ROWS [8] = '{
      '{10'h000, 16'h0F0F, 16'h0000, 16'h0000, 16'h0F0F},
      '{10'h001, 16'h00FF, 16'h0000, 16'h0000, 16'h0FF0},
      '{10'h002, 16'h3333, 16'h5555, 16'h0000, 16'h3AA3},
      '{10'h003, 16'h00FF, 16'h0F0F, 16'h0000, 16'h30FF},
      '{10'h008, 16'hFFFF, 16'h0000, 16'h0000, 16'h30FF},
      '{10'h008, 16'hFFFF, 16'h0000, 16'hFFFF, 16'hFFFF},
      '{10'h018, 16'h1234, 16'h0000, 16'h0000, 16'h1234},
      '{10'h004, 16'hC3C3, 16'h0000, 16'h0000, 16'hC3C3}
   };
   logic                         sys_clk;
   logic                         arst_n;
   logic                         avs_read;
   logic                         avs_write;
   logic [7:0]                   avs_addr;
   logic [31:0]                  avs_wdata;
   logic [3:0]                   avs_be;
   logic [31:0]                  avs_rdata;
   logic                         avs_wait;
   logic                         pin_a;
   logic                         pin_b;
   logic                         gclr_n;
   logic [NUM_MC*PT_PER_MC-1:0]  pterm;
   logic [15:0]                  fast_pin;
   logic [15:0]                  aux_t;
   logic [15:0]                  clk_t;
   logic [15:0]                  ena_t;
   logic [15:0]                  pre_t;
   logic [15:0]                  clr_t;
   logic [15:0]                  mc_out;
   int                           n_mismatch;
   int                           comparisons;

   mcr_macrocell_block #(
      .SELECTABLE_INIT (1'b1),
      .POWERUP_VALUE   (16'hA5A5)
   ) mcr_macrocell_block_inst (
      .sys_clk_i            (sys_clk),
      .arst_n_i             (arst_n),
      .avs_address_i        (avs_addr),
      .avs_read_i           (avs_read),
      .avs_write_i          (avs_write),
      .avs_writedata_i      (avs_wdata),
      .avs_byteenable_i     (avs_be),
      .avs_readdata_o       (avs_rdata),
      .avs_waitrequest_o    (avs_wait),
      .global_clock_pin_a_i (pin_a),
      .global_clock_pin_b_i (pin_b),
      .global_clear_pin_n_i (gclr_n),
      .fast_pin_i           (fast_pin),
      .pterm_i              (pterm),
      .aux_term_i           (aux_t),
      .clk_term_i           (clk_t),
      .ena_term_i           (ena_t),
      .preset_term_i        (pre_t),
      .clear_term_i         (clr_t),
      .mc_out_o             (mc_out)
   );
   mcr_array_model mcr_array_model_inst (
      .sys_clk_i            (sys_clk),
      .global_clock_pin_a_o (pin_a),
      .global_clock_pin_b_o (pin_b),
      .pterm_o              (pterm)
   );

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic conclude();
      $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge sys_clk);
      avs_read  <= !w;
      avs_write <= w;
      avs_addr  <= a;
      avs_wdata <= d;
      do begin
         @(posedge sys_clk);
      end while (avs_wait !== 1'b0);
      q = avs_rdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      cmp(q, e);
   endtask
   task automatic chk_out(input logic [15:0] e);
      @(negedge sys_clk);
      cmp({16'h0000, mc_out}, {16'h0000, e});
      @(posedge sys_clk);
   endtask
   task automatic cfg_all(input logic [9:0] v);
      for (int m = 0; m < NUM_MC; m++) begin
         wr(OFS_CFG_BASE + 8'(4*m), {22'h00_0000, v});
      end
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      n_mismatch++;
      conclude();
   end

   initial begin
      {arst_n, avs_read, avs_write, avs_addr, avs_wdata} = '0;
      {fast_pin, aux_t, clk_t, ena_t, pre_t, clr_t} = '0;
      gclr_n = 1'b1;
      avs_be = 4'hF;
      n_mismatch = 0;
      comparisons = 0;
      repeat (8) @(posedge sys_clk);
      arst_n <= 1'b1;
      rd_chk(OFS_CLKNET, 32'h0000_0004);
      rd_chk(OFS_CFG_BASE, 32'h0000_0000);
      rd_chk(OFS_STATE, 32'h0000_A5A5);
      chk_out(16'hA5A5);
      foreach (ROWS[i]) begin
         cfg_all(ROWS[i].cfg);
         mcr_array_model_inst.set_sum(ROWS[i].sum);
         aux_t <= ROWS[i].aux;
         ena_t <= ROWS[i].ena;
         mcr_array_model_inst.pulse(1'b0);
         chk_out(ROWS[i].exp);
      end
      // Net 0 from pin B, then inverted
      cfg_all(10'h000);
      wr(OFS_CLKNET, 32'h0000_0005);
      mcr_array_model_inst.set_sum(16'hAAAA);
      mcr_array_model_inst.pulse(1'b0);
      chk_out(16'hC3C3);
      mcr_array_model_inst.pulse(1'b1);
      chk_out(16'hAAAA);
      wr(OFS_CLKNET, 32'h0000_0007);
      repeat (8) @(posedge sys_clk);
      mcr_array_model_inst.set_sum(16'h5555);
      mcr_array_model_inst.set_pin(1'b1, 1'b1);
      chk_out(16'hAAAA);
      mcr_array_model_inst.set_pin(1'b1, 1'b0);
      chk_out(16'h5555);
      wr(OFS_CLKNET, 32'h0000_0004);
      // Array clock ignores global ticks and term levels
      cfg_all(10'h010);
      mcr_array_model_inst.set_sum(16'hFFFF);
      mcr_array_model_inst.pulse(1'b0);
      chk_out(16'h5555);
      clk_t <= 16'hFFFF;
      repeat (4) @(posedge sys_clk);
      chk_out(16'hFFFF);
      mcr_array_model_inst.set_sum(16'h0000);
      repeat (4) @(posedge sys_clk);
      chk_out(16'hFFFF);
      clk_t <= 16'h0000;
      cfg_all(10'h000);
      clr_t <= 16'h00FF;
      chk_out(16'hFF00);
      pre_t <= 16'hFFFF;
      chk_out(16'hFF00);
      clr_t <= 16'h0000;
      chk_out(16'hFFFF);
      pre_t <= 16'h0000;
      chk_out(16'hFFFF);
      for (int m = 0; m < 8; m++) begin
         wr(OFS_CFG_BASE + 8'(4*m), 32'h0000_0040);
      end
      gclr_n <= 1'b0;
      repeat (6) @(posedge sys_clk);
      chk_out(16'hFF00);
      gclr_n <= 1'b1;
      repeat (6) @(posedge sys_clk);
      cfg_all(10'h080);
      fast_pin <= 16'h5A5A;
      mcr_array_model_inst.pulse(1'b0);
      chk_out(16'h5A5A);
      // Expander chains in bypass mode
      cfg_all(10'h004);
      wr(8'h00, 32'h0000_0304);
      wr(8'h0C, 32'h0000_0304);
      wr(8'h20, 32'h0000_0104);
      wr(8'h24, 32'h0000_0104);
      wr(8'h30, 32'h0000_0204);
      rd_chk(OFS_EXPSET, 32'h0204_00C0);
      mcr_array_model_inst.set_terms(80'h0000_0080_0108_0000_4020);
      chk_out(16'h1288);
      wr(8'h80, 32'hFFFF_FFFF);
      rd_chk(8'h80, 32'h0000_0000);
      wr(OFS_STATE, 32'h0000_0000);
      rd_chk(OFS_STATE, 32'h0000_5A5A);
      // Byte lanes: only the low byte of the config word is written
      avs_be <= 4'h1;
      wr(8'h00, 32'hFFFF_FFFF);
      avs_be <= 4'hF;
      rd_chk(8'h00, 32'h0000_03FF);
      conclude();
   end
endmodule
